// File: logic/tuner_status_map.svh
`ifndef TUNER_STATUS_MAP_SVH
`define TUNER_STATUS_MAP_SVH
// read-frame byte order
`define BYTE_IDX_FREQ_ERR 3'h0
`define BYTE_IDX_LEVEL 3'h1
// counter result modes
`define MODE_NONE 2'h0
`define MODE_NEW 2'h1
`define MODE_HELD 2'h2
`define MODE_POR 2'h3
// power-on contents of the two bytes
`define FREQ_ERR_RESET 8'hD0
`define LEVEL_RESET 8'h00
// read addresses, strap grounded / floating
`define ADDR_READ_GND 8'hC1
`define ADDR_READ_FLOAT 8'hC3
// bytes 2 to 7 of a frame read as released bus; later bytes repeat byte 0
`define FILL_BYTE 8'hFF
// timing
`define MCLK_PERIOD_NS 4
`define ONE_MS_NS 1000000
`define AM_FILTER_MS 60
`define FILTER_SHIFT 6
`define WINDOW_FIRST_MS 6'h02
`define WINDOW_MAX_MS 6'h20
// magnitude coding
`define FINE_LIMIT 8'h0F
`define COARSE_SHIFT 3
`define MAG_MAX 4'hF
`endif

// File: logic/tuner_status_pkg.sv
package tuner_status_pkg;
	typedef enum logic [2:0] {
		LINK_IDLE = 3'b000,
		LINK_ADDR = 3'b001,
		LINK_ADDR_ACK = 3'b010,
		LINK_TX = 3'b011,
		LINK_MACK = 3'b100
	} link_state_t;
	typedef struct packed {
		logic [1:0] mode;
		logic sign;
		logic coarse;
		logic [3:0] mag;
	} freq_err_t;
	typedef struct packed {
		logic [7:0] level;
		freq_err_t freq_err;
	} status_bytes_t;
endpackage

// File: logic/tuner_status_readback.sv
`include "tuner_status_map.svh"

// Summary of operation
// - mode 00: no fresh count; magnitude shows previous or reset value.
// - mode 01: magnitude holds a newly completed count of this tuning.
// - mode 10: result from alternative-frequency update, held with level.
// - mode 11 on power-on or fault; bytes return to power-on state.
// - mode reads 00 after any tuning start until first new count.
// - bit 5 is 0 for positive, 1 for negative frequency error.
// - bit 4 selects fine (0) or coarse (1) count resolution.
// - bits 3..0 magnitude; coarse 0000 reset, 0001 unused, 1111 saturates.
// - counter restarts at PLL lock; first result 2 ms later.
// - FM results at 2,4,8,16,32 ms, then every 32 ms.
// - AM uses a fixed 2 ms window.
// - update freezes the readable count until the host reads it.
// - while frozen, background counting uses a 2 ms window.
// - byte 1 is the 8-bit level value.
// - update freezes level until the host reads it.
// - AM level passes an extra slow 60 ms filter.
// - update and check tuning report fast unfiltered level.
// - answer only read address matching the bus id strap.
// - each byte loads into the shifter on the preceding ack clock.
// - byte 0 is frequency error, byte 1 is level.
module tuner_status_readback #(
	parameter int MS_CYCLES = `ONE_MS_NS / `MCLK_PERIOD_NS,
	parameter int FILT_CYCLES = (`AM_FILTER_MS * MS_CYCLES) >> `FILTER_SHIFT
) (
	// core clock and reset
	input wire logic mclk,
	input wire logic rst,
	// tuner side
	input wire logic tune_start,
	input wire logic afu_sample,
	input wire logic check_tune,
	input wire logic pll_lock,
	input wire logic am_mode,
	input wire logic sm_fault,
	input wire logic count_sign,
	input wire logic [7:0] count_steps,
	input wire logic [7:0] level_in,
	// serial link
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic bus_id_select_pin,
	output logic sda_o,
	output logic sda_oe_n
);
	// fine steps below 16, else coarse eighths with saturation
	function automatic tuner_status_pkg::freq_err_t encode(input logic sgn, input logic [7:0] steps);
		tuner_status_pkg::freq_err_t r;
		logic [7:0] c;
		c = steps >> `COARSE_SHIFT;
		r.mode = `MODE_NEW;
		r.sign = sgn;
		r.coarse = (steps > `FINE_LIMIT);
		if (!r.coarse)
			r.mag = steps[3:0];
		else if (c > {4'h0, `MAG_MAX})
			r.mag = `MAG_MAX;
		else
			r.mag = c[3:0];
		return r;
	endfunction

	tuner_status_pkg::freq_err_t err_q;
	tuner_status_pkg::status_bytes_t pub_q, shadow_q;
	tuner_status_pkg::link_state_t st_q;
	logic [7:0] level_q, level_shown, sh_q;
	logic hold_cnt_q, hold_lev_q, counting_q, wait_lock_q, lock_q, restart;
	logic [31:0] ms_div_q, filt_div_q;
	logic [5:0] ms_cnt_q, target_q;
	logic [13:0] filt_q;
	logic [2:0] bit_q, idx_q;
	logic ms_tick, result_due, rd0_ev, rd1_ev, scl_rise, scl_fall, start_c, stop_c;
	logic rd0_s1, rd0_s2, rd0_s3, rd1_s1, rd1_s2, rd1_s3, pub_req_q, ack_s1, ack_s2;
	logic req_s1, req_s2, req_s3, link_ack_q, rd0_tgl_q, rd1_tgl_q, ackd_q;
	logic scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p, id_s1, id_s2;

	// millisecond tick from the core clock
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ms_div_q <= '0;
		else if (ms_tick || restart)
			ms_div_q <= '0; // lock restarts the divider, so the first window is a full 2 ms
		else
			ms_div_q <= ms_div_q + 32'h1;
	end
	assign ms_tick = (ms_div_q == 32'(MS_CYCLES - 1));
	assign result_due = counting_q && ms_tick && (ms_cnt_q + 6'h1 == target_q);
	assign restart = wait_lock_q && pll_lock && !lock_q;

	// lock edge tracking and count windows
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lock_q <= 1'b0;
			counting_q <= 1'b0;
			wait_lock_q <= 1'b0;
			ms_cnt_q <= '0;
			target_q <= `WINDOW_FIRST_MS;
		end else begin
			lock_q <= pll_lock;
			if (tune_start || sm_fault) begin
				counting_q <= 1'b0; // no counting until relock
				wait_lock_q <= 1'b1;
			end else if (restart) begin
				wait_lock_q <= 1'b0;
				counting_q <= 1'b1;
				ms_cnt_q <= '0;
				target_q <= `WINDOW_FIRST_MS;
			end else if (result_due) begin
				if (am_mode || hold_cnt_q) begin
					ms_cnt_q <= '0;
					target_q <= `WINDOW_FIRST_MS;
				end else if (target_q < `WINDOW_MAX_MS) begin
					ms_cnt_q <= ms_cnt_q + 6'h1;
					target_q <= target_q << 1;
				end else begin
					ms_cnt_q <= '0;
					target_q <= `WINDOW_MAX_MS;
				end
			end else if (ms_tick && counting_q)
				ms_cnt_q <= ms_cnt_q + 6'h1;
		end
	end

	// frequency error byte
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			err_q <= `FREQ_ERR_RESET;
			hold_cnt_q <= 1'b0;
		end else if (sm_fault) begin
			err_q <= `FREQ_ERR_RESET;
			hold_cnt_q <= 1'b0;
		end else begin
			if (rd0_ev)
				hold_cnt_q <= 1'b0;
			if (afu_sample) begin
				err_q <= encode(count_sign, count_steps);
				err_q.mode <= `MODE_HELD;
				hold_cnt_q <= 1'b1; // set beats release
			end else if (tune_start) begin
				err_q.mode <= `MODE_NONE;
				hold_cnt_q <= 1'b0;
			end else if (result_due && !hold_cnt_q) begin
				err_q <= encode(count_sign, count_steps);
			end
		end
	end

	// first-order detector stepped by its own divider, time constant about 60 ms in AM
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			filt_div_q <= '0;
			filt_q <= '0;
		end else if (filt_div_q >= 32'(FILT_CYCLES - 1)) begin
			filt_div_q <= '0;
			filt_q <= filt_q - (filt_q >> `FILTER_SHIFT) + {6'h0, level_in};
		end else begin
			filt_div_q <= filt_div_q + 32'h1;
		end
	end

	// fast level during update and check, filtered in AM otherwise
	always_comb begin
		if (am_mode && !check_tune && !afu_sample)
			level_shown = filt_q[13:6];
		else
			level_shown = level_in;
	end

	// level byte
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			level_q <= `LEVEL_RESET;
			hold_lev_q <= 1'b0;
		end else if (sm_fault) begin
			level_q <= `LEVEL_RESET;
			hold_lev_q <= 1'b0;
		end else begin
			if (rd1_ev)
				hold_lev_q <= 1'b0;
			if (afu_sample) begin
				level_q <= level_in;
				hold_lev_q <= 1'b1;
			end else if (!hold_lev_q || rd1_ev) begin
				level_q <= level_shown;
			end
		end
	end

	// read-done toggles from the link, three stages for edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{rd0_s1, rd0_s2, rd0_s3} <= 3'h0;
			{rd1_s1, rd1_s2, rd1_s3} <= 3'h0;
			{ack_s1, ack_s2} <= 2'h0;
		end else begin
			{rd0_s3, rd0_s2, rd0_s1} <= {rd0_s2, rd0_s1, rd0_tgl_q};
			{rd1_s3, rd1_s2, rd1_s1} <= {rd1_s2, rd1_s1, rd1_tgl_q};
			{ack_s2, ack_s1} <= {ack_s1, link_ack_q};
		end
	end
	assign rd0_ev = rd0_s2 ^ rd0_s3;
	assign rd1_ev = rd1_s2 ^ rd1_s3;

	// publish both bytes by toggle handshake; word is stable while pending
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pub_req_q <= 1'b0;
			pub_q <= {`LEVEL_RESET, `FREQ_ERR_RESET};
		end else if (pub_req_q == ack_s2) begin
			pub_q <= {level_q, err_q};
			pub_req_q <= ~pub_req_q;
		end
	end

	// pin synchronisers and handshake capture
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			{scl_s1, scl_s2, scl_p} <= 3'h7;
			{sda_s1, sda_s2, sda_p} <= 3'h7;
			{id_s1, id_s2} <= 2'h0;
			{req_s1, req_s2, req_s3} <= 3'h0;
			link_ack_q <= 1'b0;
			shadow_q <= {`LEVEL_RESET, `FREQ_ERR_RESET};
		end else begin
			{scl_p, scl_s2, scl_s1} <= {scl_s2, scl_s1, scl_i};
			{sda_p, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_i};
			{id_s2, id_s1} <= {id_s1, bus_id_select_pin};
			{req_s3, req_s2, req_s1} <= {req_s2, req_s1, pub_req_q};
			if (req_s2 != req_s3) begin
				shadow_q <= pub_q;
				link_ack_q <= req_s2;
			end
		end
	end
	assign scl_rise = scl_s2 && !scl_p;
	assign scl_fall = !scl_s2 && scl_p;
	assign start_c = scl_s2 && scl_p && !sda_s2 && sda_p;
	assign stop_c = scl_s2 && scl_p && sda_s2 && !sda_p;

	// byte picked by frame position
	function automatic logic [7:0] pick(input tuner_status_pkg::status_bytes_t s, input logic [2:0] i);
		if (i == `BYTE_IDX_FREQ_ERR)
			return s.freq_err;
		else if (i == `BYTE_IDX_LEVEL)
			return s.level;
		else
			return `FILL_BYTE;
	endfunction

	// serial read slave
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			st_q <= tuner_status_pkg::LINK_IDLE;
			sh_q <= '0;
			bit_q <= '0;
			idx_q <= '0;
			ackd_q <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_n <= 1'b1;
			rd0_tgl_q <= 1'b0;
			rd1_tgl_q <= 1'b0;
		end else if (start_c) begin
			st_q <= tuner_status_pkg::LINK_ADDR;
			bit_q <= '0;
			ackd_q <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (stop_c) begin
			st_q <= tuner_status_pkg::LINK_IDLE;
			sda_oe_n <= 1'b1;
		end else begin
			case (st_q)
			tuner_status_pkg::LINK_ADDR: begin
				if (scl_rise) begin
					sh_q <= {sh_q[6:0], sda_s2};
					bit_q <= bit_q + 3'h1;
					ackd_q <= (bit_q == 3'h7); // first fall after start must not decode
				end else if (scl_fall && ackd_q) begin
					if (sh_q == (id_s2 ? `ADDR_READ_FLOAT : `ADDR_READ_GND)) begin
						sda_oe_n <= 1'b0; // address ack
						idx_q <= `BYTE_IDX_FREQ_ERR;
						sh_q <= pick(shadow_q, `BYTE_IDX_FREQ_ERR);
						st_q <= tuner_status_pkg::LINK_ADDR_ACK;
					end else
						st_q <= tuner_status_pkg::LINK_IDLE;
				end
			end
			tuner_status_pkg::LINK_ADDR_ACK: begin
				if (scl_fall) begin
					sda_oe_n <= sh_q[7];
					bit_q <= '0;
					st_q <= tuner_status_pkg::LINK_TX;
				end
			end
			tuner_status_pkg::LINK_TX: begin
				if (scl_fall) begin
					if (bit_q == 3'h7) begin
						sda_oe_n <= 1'b1; // release for master ack
						st_q <= tuner_status_pkg::LINK_MACK;
						if (idx_q == `BYTE_IDX_FREQ_ERR)
							rd0_tgl_q <= ~rd0_tgl_q;
						if (idx_q == `BYTE_IDX_LEVEL)
							rd1_tgl_q <= ~rd1_tgl_q;
					end else begin
						sda_oe_n <= sh_q[6];
						sh_q <= {sh_q[6:0], 1'b1};
					end
					bit_q <= bit_q + 3'h1;
				end
			end
			tuner_status_pkg::LINK_MACK: begin
				if (scl_rise) begin
					ackd_q <= !sda_s2;
					if (!sda_s2) begin
						sh_q <= pick(shadow_q, idx_q + 3'h1);
						if (idx_q != 3'h7)
							idx_q <= idx_q + 3'h1;
					end
				end else if (scl_fall) begin
					if (ackd_q) begin
						sda_oe_n <= sh_q[7];
						bit_q <= '0;
						st_q <= tuner_status_pkg::LINK_TX;
					end else begin
						st_q <= tuner_status_pkg::LINK_IDLE;
					end
				end
			end
			default: st_q <= tuner_status_pkg::LINK_IDLE;
			endcase
		end
	end
endmodule

// File: verification/i2c_host_model.sv
module i2c_host_model (
	// link clock and resolved data wire
	input wire logic link_clk,
	input wire logic sda_line,
	// pins driven by the host
	output logic scl,
	output logic sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idles released
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// quarter bit; the slave needs at least 4 link cycles per half
	task automatic tick();
		repeat (4) @(posedge link_clk);
	endtask

	// data changes a quarter after scl falls, sampled mid-high
	task automatic clock_bit(input logic b, output logic s);
		sda_drv <= b;
		tick();
		scl <= 1'b1;
		tick();
		s = sda_line;
		tick();
		scl <= 1'b0;
		tick();
	endtask

	// start, address, n bytes acked but the last, stop
	task automatic read_frame(input logic [7:0] a, input int n, output logic ack, output logic [7:0] rd [8]);
		logic s;
		sda_drv <= 1'b0;
		tick();
		scl <= 1'b0;
		tick();
		for (int i = 7; i >= 0; i--) clock_bit(a[i], s);
		clock_bit(1'b1, s);
		ack = !s;
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) clock_bit(1'b1, rd[k][i]);
			clock_bit(k == n - 1, s);
		end
		sda_drv <= 1'b0;
		tick();
		scl <= 1'b1;
		tick();
		sda_drv <= 1'b1;
		tick();
	endtask
endmodule

// File: verification/tuner_status_readback_props.sv
module tuner_status_readback_props (
	// reset and link clock
	input wire logic rst,
	input wire logic link_clk,
	// link pins
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic bus_id_select_pin,
	input wire logic sda_o,
	input wire logic sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_q, sda_q;
	logic [3:0] bit_n;
	logic [7:0] addr_q;
	wire logic [7:0] own = bus_id_select_pin ? 8'hC3 : 8'hC1;
	wire logic rise = !scl_q && scl_i;

	// bit position since start; 9 means idle or past the address
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bit_n <= 4'h9;
			addr_q <= 8'h00;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			if (scl_q && scl_i && sda_q && !sda_i) begin
				bit_n <= 4'h0;
			end else if (rise && bit_n < 4'h9) begin
				bit_n <= bit_n + 4'h1;
				addr_q <= {addr_q[6:0], sda_i};
			end
		end
	end

	default clocking cb @(posedge link_clk); endclocking
	default disable iff (rst);

	chk_sda_o_low: assert property (sda_o == 1'b0) else $error("data level not low");
	chk_quiet_after_rst: assert property ($fell(rst) |-> sda_oe_n [*8]) else $error("drive after reset");
	chk_stable_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n)) else $error("sda moved");
	chk_quiet_addr: assert property (bit_n < 4'h8 && scl_i |-> sda_oe_n) else $error("drive in address");
	chk_ack_own: assert property (rise && bit_n == 4'h8 && addr_q == own |-> !sda_oe_n) else $error("no ack");
	chk_nack_other: assert property (rise && bit_n == 4'h8 && addr_q != own |-> sda_oe_n) else $error("bad ack");
	chk_ack_stands: assert property ($fell(sda_oe_n) && bit_n == 4'h8 |-> !sda_oe_n [*4]) else $error("short ack");
	chk_stop_released: assert property (scl_i && $past(scl_i) && $rose(sda_i) |=> sda_oe_n [*4]) else $error("held at stop");
endmodule

// File: verification/tuner_status_readback_test.sv
module tuner_status_readback_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, link_clk, rst, tune_start, afu_sample, check_tune, pll_lock, am_mode, sm_fault, count_sign;
	logic [7:0] count_steps, level_in;
	logic bus_id_select_pin, sda_o, sda_oe_n, scl, sda_drv, ack;
	wire logic sda_i = sda_drv & sda_oe_n;
	logic [7:0] rx [8];
	int bad_count = 0, checked = 0, cyc = 0, t0 = 0;

	// core clock, and a link clock of unrelated phase
	always #2 mclk = ~mclk;
	initial begin
		link_clk = 1'b0;
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	always @(posedge mclk) cyc <= cyc + 1;

	tuner_status_readback #(.MS_CYCLES(500), .FILT_CYCLES(40)) u_tuner_status_readback (.mclk, .rst, .tune_start,
		.afu_sample, .check_tune, .pll_lock, .am_mode, .sm_fault, .count_sign, .count_steps, .level_in,
		.link_clk, .scl_i(scl), .sda_i, .bus_id_select_pin, .sda_o, .sda_oe_n);
	i2c_host_model u_i2c_host_model (.link_clk, .sda_line(sda_i), .scl, .sda_drv);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic rd(input int n);
		u_i2c_host_model.read_frame(bus_id_select_pin ? 8'hC3 : 8'hC1, n, ack, rx);
	endtask

	// tuning start, lock 20 cycles later; t0 marks the counter restart
	task automatic tune(input logic am);
		@(posedge mclk);
		am_mode <= am;
		pll_lock <= 1'b0;
		tune_start <= 1'b1;
		@(posedge mclk);
		tune_start <= 1'b0;
		repeat (20) @(posedge mclk);
		pll_lock <= 1'b1;
		t0 = cyc;
	endtask

	// present a count, read byte 0 just after the given ms from lock
	task automatic count_at(input int ms, input logic sg, input logic [7:0] st, input logic [7:0] exp);
		@(posedge mclk);
		count_sign <= sg;
		count_steps <= st;
		while (cyc < t0 + ms * 500 + 100) @(posedge mclk);
		rd(1);
		chk(rx[0], exp);
	endtask

	task automatic addr_check();
		logic [7:0] a [4] = '{8'hC1, 8'hC3, 8'hC0, 8'hC2};
		for (int p = 0; p < 2; p++) begin
			@(posedge mclk);
			bus_id_select_pin <= p[0];
			repeat (4) @(posedge mclk);
			for (int i = 0; i < 4; i++) begin
				u_i2c_host_model.read_frame(a[i], 1, ack, rx);
				chk({7'h00, ack}, {7'h00, a[i] == (p[0] ? 8'hC3 : 8'hC1)});
			end
		end
	endtask

	task automatic fm_counts();
		tune(1'b0);
		rd(1);
		chk(rx[0] & 8'hC0, 8'h00);
		count_at(2, 1'b1, 8'h05, 8'h65);
		count_at(4, 1'b0, 8'hFF, 8'h5F);
		count_at(8, 1'b0, 8'h0F, 8'h4F);
		count_at(12, 1'b0, 8'h22, 8'h4F);
		count_at(16, 1'b0, 8'h10, 8'h52);
	endtask

	// update sample while live values keep moving behind the hold
	task automatic afu_hold();
		@(posedge mclk);
		level_in <= 8'h3C;
		count_steps <= 8'h07;
		afu_sample <= 1'b1;
		@(posedge mclk);
		afu_sample <= 1'b0;
		level_in <= 8'h55;
		count_steps <= 8'h09;
		repeat (2500) @(posedge mclk);
		rd(2);
		chk(rx[0], 8'h87);
		chk(rx[1], 8'h3C);
		rd(2);
		chk(rx[1], 8'h55);
		repeat (17000) @(posedge mclk);
		rd(1);
		chk(rx[0], 8'h49);
	endtask

	// check tuning shows fast level; otherwise the slow filter lags
	task automatic level_filter();
		@(posedge mclk);
		level_in <= 8'hC8;
		check_tune <= 1'b1;
		repeat (20) @(posedge mclk);
		rd(2);
		chk(rx[1], 8'hC8);
		@(posedge mclk);
		check_tune <= 1'b0;
		rd(2);
		chk({7'h00, rx[1] > 8'h55 && rx[1] < 8'hC8}, 8'h01);
		repeat (20000) @(posedge mclk);
		rd(2);
		chk(rx[1], 8'hC8);
	endtask

	task automatic fault_check();
		@(posedge mclk);
		sm_fault <= 1'b1;
		@(posedge mclk);
		sm_fault <= 1'b0;
		repeat (20) @(posedge mclk);
		rd(1);
		chk(rx[0], 8'hD0);
		tune(1'b0);
		rd(1);
		chk(rx[0], 8'h10);
	endtask

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{tune_start, afu_sample, check_tune, pll_lock, am_mode, sm_fault, count_sign} = 7'h00;
		count_steps = 8'h00;
		level_in = 8'h00;
		bus_id_select_pin = 1'b0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		repeat (20) @(posedge mclk);
		rd(2);
		chk(rx[0], 8'hD0);
		chk(rx[1], 8'h00);
		addr_check();
		fm_counts();
		afu_hold();
		tune(1'b1);
		count_at(2, 1'b0, 8'h03, 8'h43);
		count_at(6, 1'b0, 8'h0A, 8'h4A);
		level_filter();
		fault_check();
		give_verdict();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (95000) @(posedge mclk);
		bad_count++;
		give_verdict();
	end
endmodule

bind tuner_status_readback tuner_status_readback_props u_tuner_status_readback_props (.rst, .link_clk, .scl_i,
	.sda_i, .bus_id_select_pin, .sda_o, .sda_oe_n);
